// ---- src/lpmr_ctrl_end.sv ----
`timescale 1ns/1ps
module lpmr_ctrl_end
  import lpmr_pkg::*;
#(
  parameter logic SEG_TOP2_ZERO = 1'b0,
  parameter int HALF_CYC = LINK_HALF_CYC
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Link to memory
  lpmr_link_if.ctrl link
);
  if (HALF_CYC < 3 || HALF_CYC > 255) begin : g_bad_half
    $error("HALF_CYC must be 3 to 255");
  end

  typedef enum logic [3:0] {
    H_IDLE = 4'h1,
    H_LAUNCH = 4'h2,
    H_HOLD = 4'h4,
    H_WAIT = 4'h8
  } lpmr_hstate_t;

  // ************************************************
  // APB slave
  // ************************************************
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic acc;
  logic xfer;
  logic mapped;
  logic [31:0] rd_mux;
  lpmr_hstate_t state_q;
  logic done_q;
  logic [7:0] cmd_data_q;
  logic [5:0] cmd_ma_q;
  logic [1:0] cmd_op_q;
  logic cmd_ch_q;
  logic [7:0] rdata_q;
  logic [7:0] osc_lo_q;
  logic [7:0] osc_hi_q;

  assign acc = i_psel && i_penable;
  assign xfer = acc && pready_q;

  always_comb begin
    mapped = 1'b1;
    rd_mux = 32'h0000_0000;
    if (i_paddr == A_CMD) begin
      rd_mux[CMD_DATA_LSB +: 8] = cmd_data_q;
      rd_mux[CMD_MA_LSB +: 6] = cmd_ma_q;
      rd_mux[CMD_OP_LSB +: 2] = cmd_op_q;
      rd_mux[CMD_CH_BIT] = cmd_ch_q;
    end else if (i_paddr == A_STAT) begin
      rd_mux[STAT_BUSY_BIT] = (state_q != H_IDLE);
      rd_mux[STAT_DONE_BIT] = done_q;
    end else if (i_paddr == A_RDATA) begin
      rd_mux[7:0] = rdata_q;
    end else if (i_paddr == A_OSC) begin
      rd_mux[15:0] = {osc_hi_q, osc_lo_q};
    end else begin
      mapped = 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= acc && !pready_q;
      if (acc && !pready_q) begin
        pslverr_q <= !mapped;
        prdata_q <= i_pwrite ? 32'h0000_0000 : rd_mux;
      end
    end
  end

  assign o_pready = pready_q;
  assign o_pslverr = pslverr_q;
  assign o_prdata = prdata_q;

  // ************************************************
  // Link clock divider
  // ************************************************
  logic [7:0] div_q;
  logic lclk_q;
  logic wrap;
  logic fall;

  assign wrap = (div_q == 8'(HALF_CYC - 1));
  assign fall = wrap && lclk_q;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      div_q <= 8'h00;
      lclk_q <= 1'b0;
    end else if (wrap) begin
      div_q <= 8'h00;
      lclk_q <= !lclk_q;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end

  // ************************************************
  // Response synchroniser
  // ************************************************
  logic [8:0] rsp_s1_q;
  logic [8:0] rsp_s2_q;
  logic tog_seen_q;
  logic rsp_new;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rsp_s1_q <= 9'h000;
      rsp_s2_q <= 9'h000;
    end else begin
      rsp_s1_q <= {link.rsp_tog, link.rsp_data};
      rsp_s2_q <= rsp_s1_q;
    end
  end

  assign rsp_new = (state_q == H_WAIT) && (rsp_s2_q[8] != tog_seen_q);

  // ************************************************
  // Command sequencer
  // ************************************************
  logic cmd_go;
  logic valid_q;
  logic [7:0] wdata_in;

  assign cmd_go = xfer && i_pwrite && (i_paddr == A_CMD) && (state_q == H_IDLE);

  always_comb begin
    wdata_in = i_pwdata[CMD_DATA_LSB +: 8];
    if (SEG_TOP2_ZERO && i_pwdata[CMD_OP_LSB +: 2] == OP_MRW && i_pwdata[CMD_MA_LSB +: 6] == MA_SEG_MASK) begin
      wdata_in[7:6] = 2'b00;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cmd_data_q <= 8'h00;
      cmd_ma_q <= 6'h00;
      cmd_op_q <= OP_MRW;
      cmd_ch_q <= 1'b0;
    end else if (cmd_go) begin
      cmd_data_q <= wdata_in;
      cmd_ma_q <= i_pwdata[CMD_MA_LSB +: 6];
      cmd_op_q <= i_pwdata[CMD_OP_LSB +: 2];
      cmd_ch_q <= i_pwdata[CMD_CH_BIT];
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q <= H_IDLE;
      valid_q <= 1'b0;
    end else begin
      case (state_q)
        H_IDLE: begin
          if (cmd_go) begin
            state_q <= H_LAUNCH;
          end
        end
        H_LAUNCH: begin
          if (fall) begin
            valid_q <= 1'b1;
            state_q <= H_HOLD;
          end
        end
        H_HOLD: begin
          if (fall) begin
            valid_q <= 1'b0;
            state_q <= (cmd_op_q == OP_MRR) ? H_WAIT : H_IDLE;
          end
        end
        H_WAIT: begin
          if (rsp_new) begin
            state_q <= H_IDLE;
          end
        end
        default: begin
          state_q <= H_IDLE;
          valid_q <= 1'b0;
        end
      endcase
    end
  end

  // ************************************************
  // Read capture and status
  // ************************************************
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tog_seen_q <= 1'b0;
      rdata_q <= 8'h00;
      osc_lo_q <= 8'h00;
      osc_hi_q <= 8'h00;
    end else if (rsp_new) begin
      tog_seen_q <= rsp_s2_q[8];
      rdata_q <= rsp_s2_q[7:0];
      if (cmd_ma_q == MA_OSC_LO) begin
        osc_lo_q <= rsp_s2_q[7:0];
      end else if (cmd_ma_q == MA_OSC_HI) begin
        osc_hi_q <= rsp_s2_q[7:0];
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      done_q <= 1'b0;
    end else if (rsp_new) begin
      done_q <= 1'b1;
    end else if (xfer && i_pwrite && i_paddr == A_STAT && i_pwdata[STAT_DONE_BIT]) begin
      done_q <= 1'b0;
    end
  end

  assign link.lclk = lclk_q;
  assign link.cmd_valid = valid_q;
  assign link.ch = cmd_ch_q;
  assign link.op = cmd_op_q;
  assign link.ma = cmd_ma_q;
  assign link.wdata = cmd_data_q;
endmodule // lpmr_ctrl_end

// ---- src/lpmr_pkg.sv ----
// What this block does
// - Decode mode register addresses 11H to 15H.
// - Set mask bit suppresses that segment's self-refresh.
// - Segment is row-address bits 12:10, or upper three bits 13:11 in byte mode.
// - Separate segment mask kept for each channel.
// - Controller writes top two mask bits zero.
// - Low-byte register returns count bits 7:0.
// - High-byte register returns count bits 15:8.
// - Controller reads both bytes and concatenates.
// - Start-oscillator command clears both count bytes.
// - Controller may retune DQS from count.
// - Set invert bit inverts upper-byte pattern.
// - Upper-byte invert register resets to 55H.
// - Invert bits 0-3 DQ8-11, 4-7 DQ12-15.
// - Upper data mask line never inverted.
// - No bus inversion during read calibration.
package lpmr_pkg;
  // ************************************************
  // Mode register addresses
  // ************************************************
  localparam logic [5:0] MA_SEG_MASK = 6'h11;
  localparam logic [5:0] MA_OSC_LO = 6'h12;
  localparam logic [5:0] MA_OSC_HI = 6'h13;
  localparam logic [5:0] MA_UB_INV = 6'h14;
  localparam logic [5:0] MA_VENDOR = 6'h15;
  // ************************************************
  // Reset values and field layout
  // ************************************************
  localparam logic [7:0] SEG_MASK_RST = 8'h00;
  localparam logic [7:0] UB_INV_RST = 8'h55;
  localparam logic [7:0] RD_ZERO = 8'h00;
  localparam int SEG_BITS = 3;
  localparam int SEG_ROW_LSB = 10;
  localparam int SEG_ROW_LSB_BYTE = 11;
  localparam int OSC_W = 16;
  localparam logic [OSC_W-1:0] OSC_RST = 16'h0000;
  localparam logic [OSC_W-1:0] OSC_MAX = 16'hFFFF;
  localparam int DBI_LIMIT = 4;
  // ************************************************
  // Link commands
  // ************************************************
  typedef enum logic [1:0] {
    OP_MRW = 2'h0,
    OP_MRR = 2'h1,
    OP_OSC_START = 2'h2,
    OP_OSC_STOP = 2'h3
  } lpmr_op_t;
  // ************************************************
  // Controller APB registers
  // ************************************************
  localparam logic [11:0] A_CMD = 12'h000;
  localparam logic [11:0] A_STAT = 12'h004;
  localparam logic [11:0] A_RDATA = 12'h008;
  localparam logic [11:0] A_OSC = 12'h00C;
  localparam int CMD_DATA_LSB = 0;
  localparam int CMD_MA_LSB = 8;
  localparam int CMD_OP_LSB = 16;
  localparam int CMD_CH_BIT = 20;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  // ************************************************
  // Timing
  // ************************************************
  localparam int CLK_PERIOD_NS = 20;
  localparam int LINK_PERIOD_NS = 160;
  localparam int LINK_HALF_CYC = LINK_PERIOD_NS / (2 * CLK_PERIOD_NS);
endpackage

// ---- src/lpmr_link_if.sv ----
`timescale 1ns/1ps
interface lpmr_link_if;
  logic lclk;
  logic cmd_valid;
  logic ch;
  logic [1:0] op;
  logic [5:0] ma;
  logic [7:0] wdata;
  logic rsp_tog;
  logic [7:0] rsp_data;
  modport ctrl (output lclk, output cmd_valid, output ch, output op, output ma, output wdata,
                input rsp_tog, input rsp_data);
  modport dram (input lclk, input cmd_valid, input ch, input op, input ma, input wdata,
                output rsp_tog, output rsp_data);
endinterface

// ---- src/lpmr_cal_lane.sv ----
`timescale 1ns/1ps
module lpmr_cal_lane
  import lpmr_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Control
  input wire logic i_cal_active,
  input wire logic i_cal_bit,
  input wire logic [7:0] i_invert,
  input wire logic i_dbi_en,
  // Data
  input wire logic [7:0] i_data,
  output logic [7:0] o_dq_q,
  output logic o_dmi_q
);
  logic [3:0] ones;
  logic dbi_hit;

  always_comb begin
    ones = 4'h0;
    for (int i = 0; i < 8; i++) begin
      ones = ones + {3'h0, i_data[i]};
    end
    dbi_hit = i_dbi_en && (ones > 4'(DBI_LIMIT));
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_dq_q <= 8'h00;
      o_dmi_q <= 1'b0;
    end else if (i_cal_active) begin
      o_dq_q <= {8{i_cal_bit}} ^ i_invert;
      o_dmi_q <= i_cal_bit;
    end else begin
      o_dq_q <= dbi_hit ? ~i_data : i_data;
      o_dmi_q <= dbi_hit;
    end
  end
endmodule // lpmr_cal_lane

// ---- src/lpmr_dram_end.sv ----
`timescale 1ns/1ps
module lpmr_dram_end
  import lpmr_pkg::*;
#(
  parameter int N_CH = 2,
  parameter int ROW_W = 14
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Link to controller
  lpmr_link_if.dram link,
  // Self-refresh row query
  input wire logic i_row_ch,
  input wire logic [ROW_W-1:0] i_row_addr,
  input wire logic i_byte_mode,
  output logic o_row_refresh_en,
  output logic [N_CH*8-1:0] o_seg_mask,
  // Read calibration upper byte
  input wire logic i_cal_active,
  input wire logic i_cal_bit,
  input wire logic i_dbi_en,
  input wire logic [7:0] i_rd_data,
  output logic [7:0] o_dq_upper,
  output logic o_dmi_upper,
  // Oscillator status
  output logic [OSC_W-1:0] o_osc_count,
  output logic o_osc_running
);
  // ************************************************
  // Parameter checks
  // ************************************************
  if (N_CH < 1 || N_CH > 2) begin : g_bad_ch
    $error("N_CH must be 1 or 2");
  end
  if (ROW_W < SEG_ROW_LSB_BYTE + SEG_BITS) begin : g_bad_row
    $error("ROW_W too small for segment bits");
  end

  // ************************************************
  // Link synchroniser
  // ************************************************
  localparam int LW = 19;
  logic [LW-1:0] link_raw;
  logic [LW-1:0] link_s1_q;
  logic [LW-1:0] link_s2_q;
  logic lclk_d_q;
  logic s_lclk;
  logic s_valid;
  logic s_ch;
  logic [1:0] s_op;
  logic [5:0] s_ma;
  logic [7:0] s_wdata;
  logic rise;
  logic fire;

  assign link_raw = {link.lclk, link.cmd_valid, link.ch, link.op, link.ma, link.wdata};
  assign {s_lclk, s_valid, s_ch, s_op, s_ma, s_wdata} = link_s2_q;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      link_s1_q <= '0;
      link_s2_q <= '0;
      lclk_d_q <= 1'b0;
    end else begin
      link_s1_q <= link_raw;
      link_s2_q <= link_s1_q;
      lclk_d_q <= s_lclk;
    end
  end

  assign rise = s_lclk && !lclk_d_q;
  assign fire = rise && s_valid;

  // ************************************************
  // Address decode
  // ************************************************
  logic wr_seg;
  logic wr_inv;
  logic do_rd;
  logic osc_start;
  logic osc_stop;

  always_comb begin
    wr_seg = 1'b0;
    wr_inv = 1'b0;
    do_rd = fire && (s_op == OP_MRR);
    osc_start = fire && (s_op == OP_OSC_START);
    osc_stop = fire && (s_op == OP_OSC_STOP);
    if (fire && s_op == OP_MRW && s_ma == MA_SEG_MASK) begin
      wr_seg = 1'b1;
    end else if (fire && s_op == OP_MRW && s_ma == MA_UB_INV) begin
      wr_inv = 1'b1;
    end
  end

  // ************************************************
  // Segment masks per channel
  // ************************************************
  logic [7:0] seg_mask_q [N_CH];

  for (genvar g = 0; g < N_CH; g++) begin : g_ch
    logic hit;
    assign hit = (N_CH == 1) || (s_ch == 1'(g));
    always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
        seg_mask_q[g] <= SEG_MASK_RST;
      end else if (wr_seg && hit) begin
        seg_mask_q[g] <= s_wdata;
      end
    end
    assign o_seg_mask[g*8 +: 8] = seg_mask_q[g];
  end

  // ************************************************
  // Row refresh decision
  // ************************************************
  logic [SEG_BITS-1:0] row_seg;
  logic [7:0] row_mask;
  logic row_refresh_en_q;

  always_comb begin
    row_seg = i_byte_mode ? i_row_addr[SEG_ROW_LSB_BYTE +: SEG_BITS] : i_row_addr[SEG_ROW_LSB +: SEG_BITS];
    row_mask = (i_row_ch && N_CH > 1) ? seg_mask_q[N_CH-1] : seg_mask_q[0];
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      row_refresh_en_q <= 1'b1;
    end else begin
      row_refresh_en_q <= !row_mask[row_seg];
    end
  end

  assign o_row_refresh_en = row_refresh_en_q;

  // ************************************************
  // Upper byte invert register
  // ************************************************
  logic [7:0] ub_inv_q;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ub_inv_q <= UB_INV_RST;
    end else if (wr_inv) begin
      ub_inv_q <= s_wdata;
    end
  end

  // ************************************************
  // Interval oscillator count
  // ************************************************
  logic [OSC_W-1:0] osc_cnt_q;
  logic osc_run_q;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      osc_run_q <= 1'b0;
    end else if (osc_start) begin
      osc_run_q <= 1'b1;
    end else if (osc_stop) begin
      osc_run_q <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      osc_cnt_q <= OSC_RST;
    end else if (osc_start) begin
      osc_cnt_q <= OSC_RST;
    end else if (rise && osc_run_q && osc_cnt_q != OSC_MAX) begin
      osc_cnt_q <= osc_cnt_q + 16'h0001;
    end
  end

  assign o_osc_count = osc_cnt_q;
  assign o_osc_running = osc_run_q;

  // ************************************************
  // Mode register read
  // ************************************************
  logic [7:0] rd_mux;
  logic rsp_tog_q;
  logic [7:0] rsp_data_q;

  always_comb begin
    if (s_ma == MA_OSC_LO) begin
      rd_mux = osc_cnt_q[7:0];
    end else if (s_ma == MA_OSC_HI) begin
      rd_mux = osc_cnt_q[15:8];
    end else if (s_ma == MA_VENDOR) begin
      rd_mux = RD_ZERO;
    end else begin
      rd_mux = RD_ZERO;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rsp_tog_q <= 1'b0;
      rsp_data_q <= RD_ZERO;
    end else if (do_rd) begin
      rsp_data_q <= rd_mux;
      rsp_tog_q <= !rsp_tog_q;
    end
  end

  assign link.rsp_tog = rsp_tog_q;
  assign link.rsp_data = rsp_data_q;

  // ************************************************
  // Read calibration lane
  // ************************************************
  lpmr_cal_lane u_lane (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_cal_active(i_cal_active),
    .i_cal_bit(i_cal_bit),
    .i_invert(ub_inv_q),
    .i_dbi_en(i_dbi_en),
    .i_data(i_rd_data),
    .o_dq_q(o_dq_upper),
    .o_dmi_q(o_dmi_upper)
  );
endmodule // lpmr_dram_end

// ---- tb/lpmr_properties.sv ----
`timescale 1ns/1ps
module lpmr_properties
  import lpmr_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Link
  input wire logic lclk,
  input wire logic cmd_valid,
  input wire logic ch,
  input wire logic [1:0] op,
  input wire logic [5:0] ma,
  input wire logic [7:0] wdata,
  input wire logic rsp_tog,
  input wire logic [7:0] rsp_data
);
  // ****
  // Link checks
  // ****
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  property p_fields_stable;
    cmd_valid && $past(cmd_valid) |-> $stable({ch, op, ma, wdata});
  endproperty
  a_fields_stable: assert property (p_fields_stable) else $error("fields moved");
  property p_launch_low;
    $rose(cmd_valid) |-> !lclk;
  endproperty
  a_launch_low: assert property (p_launch_low) else $error("launch not on low clock");
  property p_valid_width;
    $rose(cmd_valid) |-> cmd_valid [*8] ##1 !cmd_valid;
  endproperty
  a_valid_width: assert property (p_valid_width) else $error("command width");
  property p_mrr_ans;
    $rose(cmd_valid) && op == OP_MRR |-> ##[1:24] $changed(rsp_tog);
  endproperty
  a_mrr_ans: assert property (p_mrr_ans) else $error("no read answer");
  property p_mrw_quiet;
    $rose(cmd_valid) && op != OP_MRR |-> $stable(rsp_tog) [*8];
  endproperty
  a_mrw_quiet: assert property (p_mrw_quiet) else $error("answer without read");
  property p_seg_rd_zero;
    $rose(cmd_valid) && op == OP_MRR && ma == MA_SEG_MASK |-> ##[1:24] ($changed(rsp_tog) && rsp_data == 8'h00);
  endproperty
  a_seg_rd_zero: assert property (p_seg_rd_zero) else $error("mask read not zero");
  property p_inv_rd_zero;
    $rose(cmd_valid) && op == OP_MRR && ma == MA_UB_INV |-> ##[1:24] ($changed(rsp_tog) && rsp_data == 8'h00);
  endproperty
  a_inv_rd_zero: assert property (p_inv_rd_zero) else $error("invert read not zero");
  property p_vnd_rd_zero;
    $rose(cmd_valid) && op == OP_MRR && ma == MA_VENDOR |-> ##[1:24] ($changed(rsp_tog) && rsp_data == 8'h00);
  endproperty
  a_vnd_rd_zero: assert property (p_vnd_rd_zero) else $error("vendor read not zero");
  property p_rsp_hold;
    !$changed(rsp_tog) |-> $stable(rsp_data);
  endproperty
  a_rsp_hold: assert property (p_rsp_hold) else $error("answer data moved");
endmodule // lpmr_properties

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
module tb_top
  import lpmr_pkg::*;
;
  logic i_clk;
  logic i_rst_n;
  logic psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic row_ch, byte_mode, row_en, cal_act, cal_bit, dbi_en, dmi, osc_run, e;
  logic [13:0] row_addr;
  logic [7:0] rd_data, dq, lo, hi;
  logic [15:0] seg_mask, osc_cnt, first;
  int err_total;
  int total_checks;
  logic osc_on = 1'b0;
  logic [15:0] osc_exp = 16'h0000;
  lpmr_link_if link_if_inst ();
  lpmr_ctrl_end lpmr_ctrl_end_inst (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .link(link_if_inst));
  lpmr_dram_end lpmr_dram_end_inst (.i_clk(i_clk), .i_rst_n(i_rst_n), .link(link_if_inst), .i_row_ch(row_ch),
    .i_row_addr(row_addr), .i_byte_mode(byte_mode), .o_row_refresh_en(row_en), .o_seg_mask(seg_mask),
    .i_cal_active(cal_act), .i_cal_bit(cal_bit), .i_dbi_en(dbi_en), .i_rd_data(rd_data), .o_dq_upper(dq),
    .o_dmi_upper(dmi), .o_osc_count(osc_cnt), .o_osc_running(osc_run));
  lpmr_properties lpmr_properties_inst (.i_clk(i_clk), .i_rst_n(i_rst_n), .lclk(link_if_inst.lclk),
    .cmd_valid(link_if_inst.cmd_valid), .ch(link_if_inst.ch), .op(link_if_inst.op), .ma(link_if_inst.ma),
    .wdata(link_if_inst.wdata), .rsp_tog(link_if_inst.rsp_tog), .rsp_data(link_if_inst.rsp_data));
  // Reference count of link clock rises between start and stop
  always @(posedge link_if_inst.lclk) begin
    if (link_if_inst.cmd_valid && link_if_inst.op == OP_OSC_START) begin
      osc_exp <= 16'h0000;
      osc_on <= 1'b1;
    end else if (osc_on) begin
      osc_exp <= osc_exp + 16'h0001;
      osc_on <= !(link_if_inst.cmd_valid && link_if_inst.op == OP_OSC_STOP);
    end
  end
  // ****
  // Shared tasks
  // ****
  task stop_test;
    if (err_total == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge i_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      err_total++;
      stop_test;
    end
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task mr(input logic [1:0] o, input logic [5:0] a, input logic [7:0] d, input logic c);
    int n;
    apb(1'b1, A_CMD, {11'h000, c, 2'h0, o, 2'h0, a, d});
    n = 0;
    do begin
      apb(1'b0, A_STAT, 32'h0);
      n++;
    end while (rd[STAT_BUSY_BIT] !== 1'b0 && n < 100);
    if (n >= 100) begin
      err_total++;
      stop_test;
    end
  endtask
  task mrr(input logic [5:0] a, output logic [7:0] v);
    mr(OP_MRR, a, 8'h00, 1'b0);
    chk(rd[STAT_DONE_BIT], 1'b1);
    apb(1'b0, A_RDATA, 32'h0);
    v = rd[7:0];
    chk(e, 1'b0);
    apb(1'b1, A_STAT, 32'h0000_0002);
    apb(1'b0, A_STAT, 32'h0);
    chk(rd[STAT_DONE_BIT], 1'b0);
  endtask
  task drive_row(input logic c, input logic [13:0] a, input logic b);
    @(posedge i_clk);
    row_ch <= c;
    row_addr <= a;
    byte_mode <= b;
    @(posedge i_clk);
    @(negedge i_clk);
  endtask
  task drive_cal(input logic act, input logic b, input logic dbi, input logic [7:0] d);
    @(posedge i_clk);
    cal_act <= act;
    cal_bit <= b;
    dbi_en <= dbi;
    rd_data <= d;
    @(posedge i_clk);
    @(negedge i_clk);
  endtask
  // ****
  // Scenarios
  // ****
  task t_reset_vals;
    chk(seg_mask, 16'h0000);
    chk(row_en, 1'b1);
    drive_cal(1'b1, 1'b0, 1'b0, 8'h00);
    chk(dq, 8'h55);
    chk(dmi, 1'b0);
    mrr(MA_SEG_MASK, lo);
    mrr(MA_UB_INV, lo);
    mrr(MA_VENDOR, lo);
    chk(lo, 8'h00);
    apb(1'b0, 12'h010, 32'h0);
    chk(rd, 32'h0000_0000);
    chk(e, 1'b1);
  endtask
  task t_seg;
    mr(OP_MRW, MA_SEG_MASK, 8'hA5, 1'b0);
    mr(OP_MRW, MA_SEG_MASK, 8'h3C, 1'b1);
    chk(seg_mask, 16'h3CA5);
    for (int n = 0; n < 8; n++) begin
      drive_row(1'b0, 14'h2200 | 14'(n << 10), 1'b0);
      chk(row_en, !(8'hA5 >> n & 8'h01));
      drive_row(1'b1, 14'h0400 | 14'(n << 11), 1'b1);
      chk(row_en, !(8'h3C >> n & 8'h01));
    end
  endtask
  task t_inv;
    logic [7:0] m[2];
    m = '{8'h96, 8'h0F};
    for (int k = 0; k < 2; k++) begin
      mr(OP_MRW, MA_UB_INV, m[k], 1'b0);
      drive_cal(1'b1, 1'b1, 1'b1, 8'hFF);
      chk({dmi, dq}, {1'b1, ~m[k]});
      drive_cal(1'b1, 1'b0, 1'b1, 8'hFF);
      chk({dmi, dq}, {1'b0, m[k]});
    end
    drive_cal(1'b0, 1'b0, 1'b1, 8'hFF);
    chk({dmi, dq}, {1'b1, 8'h00});
  endtask
  task t_osc;
    mr(OP_OSC_START, 6'h00, 8'h00, 1'b0);
    chk(osc_run, 1'b1);
    repeat (2200) @(posedge i_clk);
    mr(OP_OSC_STOP, 6'h00, 8'h00, 1'b0);
    chk(osc_run, 1'b0);
    mr(OP_MRW, MA_OSC_LO, 8'hFF, 1'b0);
    mrr(MA_OSC_LO, lo);
    mrr(MA_OSC_HI, hi);
    chk(lo, osc_exp[7:0]);
    chk(hi, osc_exp[15:8]);
    chk(osc_cnt, osc_exp);
    apb(1'b0, A_OSC, 32'h0);
    chk(rd[15:0], osc_exp);
    first = {hi, lo};
    mr(OP_OSC_START, 6'h00, 8'h00, 1'b0);
    mr(OP_OSC_STOP, 6'h00, 8'h00, 1'b0);
    mrr(MA_OSC_LO, lo);
    mrr(MA_OSC_HI, hi);
    chk({hi, lo} < first, 1'b1);
    chk({hi, lo}, osc_exp);
  endtask
  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end
  initial begin
    err_total = 0;
    total_checks = 0;
    i_rst_n = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {row_ch, byte_mode, row_addr, cal_act, cal_bit, dbi_en, rd_data} = '0;
    repeat (6) @(posedge i_clk);
    i_rst_n <= 1'b1;
    t_reset_vals;
    t_seg;
    t_inv;
    t_osc;
    stop_test;
  end
endmodule // tb_top
